/* File: include/mlcd_pkg.sv */
// package for the modem line change detector: offsets, fields, reset values
`default_nettype none
package mlcd_pkg;
  // ****************************************
  // register offsets (8-bit address space)
  // ****************************************
  localparam logic [7:0] OFF_CHANGE_OPTIONS_ONE = 8'h10;
  localparam logic [7:0] OFF_CHANGE_OPTIONS_TWO = 8'h11;
  localparam logic [7:0] OFF_CHANGE_FLAGS = 8'h12;
  localparam logic [7:0] OFF_SIGNAL_VALUES = 8'h28;
  localparam logic [7:0] OFF_END_OF_SERVICE = 8'h7f;
  localparam logic [7:0] OFF_SERVICE_ENABLE = 8'h7e;
  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_SET_READY = 7;
  localparam int BIT_CARRIER = 6;
  localparam int BIT_CLEAR_SEND = 5;
  localparam int BIT_THRESH_LO = 0;
  localparam int THRESH_W = 4;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_OPTIONS_ONE = 8'h00;
  localparam logic [7:0] RST_OPTIONS_TWO = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [2:0] RST_SYNC = 3'h0;
  localparam logic [3:0] RST_RX_THRESH = 4'h8;
  // three modem inputs travel together, ordered set_ready, carrier, clear_send
  typedef struct packed {
    logic set_ready;
    logic carrier;
    logic clear_send;
  } mlcd_lines_t;
endpackage
`default_nettype wire

/* File: core/mlcd_detect.sv */
// modem line change detector for one serial channel
// Function
// - selected transition on a monitored modem input sets its change flag
// - a change raises the modem service request only when its enable is set
// - after request asserts, detected changes stop setting flags until end-of-service is written; host writes still load them
// - flags: bit 7 set-ready, bit 6 carrier, bit 5 clear-send; 4:0 read zero
// - option-one bit 7 detects set-ready pin falling (value bit rising)
// - option-one bit 6 detects carrier pin falling (value bit rising)
// - option-one bit 5 detects clear-send pin falling (value bit rising)
// - option-one bits 3:0 give auto terminal-ready threshold, capped at RX_SERVICE_THRESH; zero disables
// - option-two bits 7..5 detect pin rising (value bit falling) per line
// - value bits are the inverse of the pin levels
`timescale 1ns/100ps
`default_nettype none
module mlcd_detect #(
  parameter logic [3:0] RX_SERVICE_THRESH = mlcd_pkg::RST_RX_THRESH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  input wire logic set_ready_n,
  input wire logic carrier_n,
  input wire logic clear_send_n,
  input wire logic [3:0] rx_fifo_level,
  output logic modem_service_req,
  output logic auto_terminal_ready_en,
  output logic [3:0] auto_terminal_ready_level,
  output logic rx_level_over_thresh
);
  // ****************************************
  // address decoding
  // ****************************************
  // true when the bus address selects the given register offset
  function automatic logic reg_sel(
    input logic [7:0] addr,
    input logic [7:0] off
  );
    return (addr == off);
  endfunction

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [2:0] sync_q [3];
  logic [2:0] pins_n;
  logic [2:0] stable_v;
  logic [2:0] val_q;
  logic [2:0] val_d;
  mlcd_pkg::mlcd_lines_t lines_v;
  assign pins_n = {set_ready_n, carrier_n, clear_send_n};

  // filtered value bits as one named group for the status read
  assign lines_v = val_q;

  // three stages per pin; a change counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (rst) begin
          sync_q[g] <= mlcd_pkg::RST_SYNC;
        end else begin
          sync_q[g] <= {sync_q[g][1:0], ~pins_n[g]};
        end
      end
      assign stable_v[g] = (sync_q[g][1] == sync_q[g][2]);
      assign val_d[g] = stable_v[g] ? sync_q[g][2] : val_q[g];
    end
  endgenerate

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] opt1_q;
  logic [7:0] opt2_q;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] srv_en_q;
  logic [7:0] opt1_d;
  logic [7:0] opt2_d;
  logic [7:0] srv_en_d;
  logic svc_q;
  logic svc_d;
  logic wr_opt1;
  logic wr_opt2;
  logic wr_flags;
  logic wr_eos;
  logic wr_en;
  // one write strobe per register except signal values, which is read-only; unmapped writes select nothing
  assign wr_opt1 = bus_wr && reg_sel(bus_addr, mlcd_pkg::OFF_CHANGE_OPTIONS_ONE);
  assign wr_opt2 = bus_wr && reg_sel(bus_addr, mlcd_pkg::OFF_CHANGE_OPTIONS_TWO);
  assign wr_flags = bus_wr && reg_sel(bus_addr, mlcd_pkg::OFF_CHANGE_FLAGS);
  assign wr_eos = bus_wr && reg_sel(bus_addr, mlcd_pkg::OFF_END_OF_SERVICE);
  assign wr_en = bus_wr && reg_sel(bus_addr, mlcd_pkg::OFF_SERVICE_ENABLE);

  // ****************************************
  // transition detection
  // ****************************************
  logic [2:0] rise_v;
  logic [2:0] fall_v;
  logic [2:0] fall_en;
  logic [2:0] rise_en;
  logic [2:0] hit;
  logic [7:0] hit_byte;
  assign rise_v = val_d & ~val_q;
  assign fall_v = ~val_d & val_q;
  assign fall_en = opt1_q[7:5];
  assign rise_en = opt2_q[7:5];
  assign hit = (rise_v & fall_en) | (fall_v & rise_en);
  assign hit_byte = {hit, 5'h00};

  // flags: host write clears/loads, detection sets, frozen while in service
  always_comb begin
    flags_d = flags_q;
    if (wr_flags) begin
      flags_d = {bus_wdata[7:5], 5'h00};
    end
    if (!svc_q) begin
      flags_d = flags_d | hit_byte; // set wins over clear
    end
  end

  // request rises on an enabled change, holds until end-of-service
  assign svc_d = wr_eos ? 1'b0 : (svc_q | (|(hit_byte & srv_en_q)));

  // next values of option and enable registers; unused bits stay zero
  assign opt1_d = wr_opt1 ? {bus_wdata[7:5], 1'b0, bus_wdata[3:0]} : opt1_q;
  assign opt2_d = wr_opt2 ? {bus_wdata[7:5], 5'h00} : opt2_q;
  assign srv_en_d = wr_en ? {bus_wdata[7:5], 5'h00} : srv_en_q;

  // option register one: fall enables and threshold
  always_ff @(posedge mclk) begin
    if (rst) begin
      opt1_q <= mlcd_pkg::RST_OPTIONS_ONE;
    end else begin
      opt1_q <= opt1_d;
    end
  end

  // option register two: rise enables
  always_ff @(posedge mclk) begin
    if (rst) begin
      opt2_q <= mlcd_pkg::RST_OPTIONS_TWO;
    end else begin
      opt2_q <= opt2_d;
    end
  end

  // per-line service request enables
  always_ff @(posedge mclk) begin
    if (rst) begin
      srv_en_q <= mlcd_pkg::RST_FLAGS;
    end else begin
      srv_en_q <= srv_en_d;
    end
  end

  // change flags
  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_q <= mlcd_pkg::RST_FLAGS;
    end else begin
      flags_q <= flags_d;
    end
  end

  // service request; changes seen while it stands are lost, not queued
  always_ff @(posedge mclk) begin
    if (rst) begin
      svc_q <= 1'b0;
    end else begin
      svc_q <= svc_d;
    end
  end

  // filtered value bits; reset assumes idle-high pins, so held-low pins edge later
  always_ff @(posedge mclk) begin
    if (rst) begin
      val_q <= 3'h0;
    end else begin
      val_q <= val_d;
    end
  end

  // ****************************************
  // automatic terminal-ready threshold
  // ****************************************
  logic [3:0] thr_raw;
  logic [3:0] thr_eff;
  assign thr_raw = opt1_q[3:0];
  assign thr_eff = (thr_raw > RX_SERVICE_THRESH) ? RX_SERVICE_THRESH : thr_raw;
  assign auto_terminal_ready_en = (thr_raw != 4'h0);
  assign auto_terminal_ready_level = thr_eff;
  assign rx_level_over_thresh = auto_terminal_ready_en && (rx_fifo_level >= thr_eff);
  assign modem_service_req = svc_q;

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    bus_rdata = 8'h00;
    if (bus_rd) begin
      unique case (bus_addr)
        mlcd_pkg::OFF_CHANGE_OPTIONS_ONE: bus_rdata = opt1_q;
        mlcd_pkg::OFF_CHANGE_OPTIONS_TWO: bus_rdata = opt2_q;
        mlcd_pkg::OFF_CHANGE_FLAGS: bus_rdata = flags_q;
        mlcd_pkg::OFF_SIGNAL_VALUES: bus_rdata = {lines_v, 5'h00};
        mlcd_pkg::OFF_SERVICE_ENABLE: bus_rdata = srv_en_q;
        default: bus_rdata = 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: bench/mlcd_checker.sv */
// port checker for the modem line change detector
`timescale 1ns/100ps
`default_nettype none
module mlcd_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  input wire logic [3:0] rx_fifo_level,
  input wire logic modem_service_req,
  input wire logic auto_terminal_ready_en,
  input wire logic [3:0] auto_terminal_ready_level,
  input wire logic rx_level_over_thresh
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // host writes flags while frozen, then reads the written value back
  sequence s_clr; bus_wr && bus_addr == 8'h12 && modem_service_req; endsequence
  sequence s_chk; bus_rd && bus_addr == 8'h12 && modem_service_req; endsequence
  property p_hold; s_clr ##2 s_chk |-> bus_rdata[7:5] == $past(bus_wdata[7:5], 2); endproperty
  a_hold: assert property (p_hold) else $error("frozen");
  property p_lo; bus_rd && bus_addr == 8'h12 |-> bus_rdata[4:0] == 5'h00; endproperty
  a_lo: assert property (p_lo) else $error("low bits");
  property p_rd0; !bus_rd |-> bus_rdata == 8'h00; endproperty
  a_rd0: assert property (p_rd0) else $error("idle data");
  property p_en; bus_wr && bus_addr == 8'h10 |=> auto_terminal_ready_en == $past(|bus_wdata[3:0]); endproperty
  a_en: assert property (p_en) else $error("auto en");
  property p_over; rx_level_over_thresh == (auto_terminal_ready_en && rx_fifo_level >= auto_terminal_ready_level); endproperty
  a_over: assert property (p_over) else $error("over");
  property p_eos; bus_wr && bus_addr == 8'h7f |=> !modem_service_req; endproperty
  a_eos: assert property (p_eos) else $error("eos");
  property p_req; modem_service_req && !(bus_wr && bus_addr == 8'h7f) |=> modem_service_req; endproperty
  a_req: assert property (p_req) else $error("req drop");
  property p_rst; $past(rst) |-> !modem_service_req && !auto_terminal_ready_en; endproperty
  a_rst: assert property (p_rst) else $error("reset");
endmodule
bind mlcd_detect mlcd_checker u_chk (.*);
`default_nettype wire

/* File: bench/mlcd_modem.sv */
// modem model driving the three active-low control pins
`timescale 1ns/100ps
`default_nettype none
module mlcd_modem (
  input wire logic [2:0] want,
  output logic [2:0] pins_n
);
  // pins show the asked value bits inverted, after a line delay
  initial pins_n = 3'h7;
  always @(want) pins_n <= #3 ~want;
endmodule
`default_nettype wire

/* File: bench/mlcd_detect_tb.sv */
// self-checking bench for the modem line change detector
`timescale 1ns/100ps
`default_nettype none
module mlcd_detect_tb;
  localparam logic [3:0] th = 4'h6;
  logic mclk = 1'b0, rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, req;
  logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata, r = 8'h37, q[$];
  logic [3:0] rx_fifo_level = 4'h0, lvl;
  logic [2:0] want = 3'h0, pins_n;
  logic ate, over;
  int num_errors = 0, tests_run = 0;
  always #5 mclk = ~mclk;
  mlcd_modem modem (.want(want), .pins_n(pins_n));
  mlcd_detect #(.RX_SERVICE_THRESH(th)) uut (.mclk(mclk), .rst(rst), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .set_ready_n(pins_n[2]), .carrier_n(pins_n[1]), .clear_send_n(pins_n[0]),
    .rx_fifo_level(rx_fifo_level), .modem_service_req(req), .auto_terminal_ready_en(ate),
    .auto_terminal_ready_level(lvl), .rx_level_over_thresh(over));
  function automatic logic [7:0] lf(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  // bus cycles: write strobe or read enable for one clock
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #1 {bus_wr, bus_addr, bus_wdata} = {1'b1, a, d};
    @(posedge mclk) #1 bus_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk) #1 {bus_rd, bus_addr} = {1'b1, a};
    q.push_back(e);
    @(posedge mclk) #1 bus_rd = 1'b0;
  endtask
  // oldest expected read value against the data seen now
  always @(negedge mclk) if (bus_rd === 1'b1) chk(bus_rdata, q.pop_front());
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    #1 rst = 1'b0;
    rd(8'h12, 8'h00);
    rd(8'h55, 8'h00);
    repeat (4) begin
      r = lf(r);
      rx_fifo_level = r[7:4];
      wr(8'h10, r & 8'hef);
      rd(8'h10, r & 8'hef);
      chk({4'h0, lvl}, {4'h0, (r[3:0] > th) ? th : r[3:0]});
      chk({6'h00, ate, over}, {6'h00, r[3:0] != 4'h0,
        (r[3:0] != 4'h0) && (r[7:4] >= ((r[3:0] > th) ? th : r[3:0]))});
    end
    for (int b = 5; b < 8; b++) begin
      wr(8'h10, 8'h01 << b);
      wr(8'h11, 8'h01 << b);
      wr(8'h7e, 8'h01 << b);
      want[b-5] = 1'b1;
      repeat (6) @(posedge mclk);
      rd(8'h12, 8'h01 << b);
      chk({7'h00, req}, 8'h01);
      wr(8'h12, 8'h00);
      rd(8'h12, 8'h00);
      want[b-5] = 1'b0;
      repeat (6) @(posedge mclk);
      rd(8'h12, 8'h00);
      wr(8'h7f, 8'h00);
      wr(8'h7e, 8'h00);
      want[b-5] = 1'b1;
      repeat (6) @(posedge mclk);
      rd(8'h12, 8'h01 << b);
      wr(8'h12, 8'h00);
      want[b-5] = 1'b0;
      repeat (6) @(posedge mclk);
      rd(8'h12, 8'h01 << b);
      chk({7'h00, req}, 8'h00);
      wr(8'h12, 8'h00);
    end
    report_and_stop();
  end
  initial begin
    #20000;
    num_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
